// ---- rtl/fifo_ctl_pkg.sv ----
// Shared constants and types for the dual-port FIFO controller
package fifo_ctl_pkg;
    localparam int DATA_W = 18;
    localparam int HALF_W = 9;
    localparam int DEPTH_LOG2 = 6;
    localparam int OFFS_W = DEPTH_LOG2 + 1;
    localparam int SYNC_STAGES = 3;
    localparam logic [OFFS_W-1:0] EMPTY_OFFS_RST = 7'h07;
    localparam logic [OFFS_W-1:0] FULL_OFFS_RST = 7'h07;
    localparam logic [DATA_W-1:0] DATA_ZERO = 18'h00000;

    typedef struct packed {
        logic narrow_read;
        logic sync_flags;
        logic normal_rt_latency;
        logic fall_through;
        logic async_read;
        logic async_write;
    } mode_cfg_t;

    typedef struct packed {
        logic [OFFS_W-1:0] empty_offs;
        logic [OFFS_W-1:0] full_offs;
    } offsets_t;
endpackage

// ---- rtl/fifo_ctl.sv ----
// Dual-port FIFO controller with programmable almost flags and reread
`timescale 1ns/1ps
`default_nettype none
module fifo_ctl
    import fifo_ctl_pkg::*;
#(
    parameter int DEPTH_W = DEPTH_LOG2
)(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic master_reset_n_i,
    input wire logic partial_reset_n_i,
    input wire logic read_width_select_i,
    input wire logic flag_timing_select_i,
    input wire logic retransmit_latency_select_i,
    input wire logic async_read_select_n_i,
    input wire logic async_write_select_n_i,
    input wire logic fall_through_mode_i,
    input wire logic write_clk_i,
    input wire logic write_enable_n_i,
    input wire logic [DATA_W-1:0] write_data_i,
    input wire logic read_clk_i,
    input wire logic read_enable_n_i,
    input wire logic output_enable_n_i,
    input wire logic offset_access_n_i,
    input wire logic serial_offset_load_enable_n_i,
    input wire logic reread_request_i,
    output logic [DATA_W-1:0] read_data_out_o,
    output logic [DATA_W-1:0] read_data_out_en_n_o,
    output logic empty_flag_n_o,
    output logic almost_empty_flag_n_o,
    output logic almost_full_flag_n_o
);
    localparam int DEPTH = 1 << DEPTH_W;
    localparam logic [DEPTH_W:0] DEPTH_CNT = (DEPTH_W+1)'(DEPTH);

    // Three-stage samplers for the port clock, reset and reread pins from outside this clock
    logic [SYNC_STAGES-1:0] wclk_s_q, rclk_s_q, mr_s_q, pr_s_q, rt_s_q;
    logic [SYNC_STAGES-1:0] wclk_s_d, rclk_s_d, mr_s_d, pr_s_d, rt_s_d;
    always_comb
    begin
        wclk_s_d = {wclk_s_q[SYNC_STAGES-2:0], write_clk_i};
        rclk_s_d = {rclk_s_q[SYNC_STAGES-2:0], read_clk_i};
        mr_s_d = {mr_s_q[SYNC_STAGES-2:0], master_reset_n_i};
        pr_s_d = {pr_s_q[SYNC_STAGES-2:0], partial_reset_n_i};
        rt_s_d = {rt_s_q[SYNC_STAGES-2:0], reread_request_i};
    end
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wclk_s_q <= '0;
            rclk_s_q <= '0;
            mr_s_q <= '0;
            pr_s_q <= '1;
            rt_s_q <= '0;
        end
        else
        begin
            wclk_s_q <= wclk_s_d;
            rclk_s_q <= rclk_s_d;
            mr_s_q <= mr_s_d;
            pr_s_q <= pr_s_d;
            rt_s_q <= rt_s_d;
        end
    end

    // Settled levels only change once stages two and three agree
    logic wclk_lvl_q, rclk_lvl_q, mr_n_q, pr_n_q, rt_lvl_q;
    logic wclk_lvl_d, rclk_lvl_d, mr_n_d, pr_n_d, rt_lvl_d;
    function automatic logic settle(input logic [SYNC_STAGES-1:0] s, input logic cur);
        settle = (s[1] == s[2]) ? s[2] : cur;
    endfunction
    always_comb
    begin
        wclk_lvl_d = settle(wclk_s_q, wclk_lvl_q);
        rclk_lvl_d = settle(rclk_s_q, rclk_lvl_q);
        mr_n_d = settle(mr_s_q, mr_n_q);
        pr_n_d = settle(pr_s_q, pr_n_q);
        rt_lvl_d = settle(rt_s_q, rt_lvl_q);
    end
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wclk_lvl_q <= 1'b0;
            rclk_lvl_q <= 1'b0;
            mr_n_q <= 1'b0;
            pr_n_q <= 1'b1;
            rt_lvl_q <= 1'b0;
        end
        else
        begin
            wclk_lvl_q <= wclk_lvl_d;
            rclk_lvl_q <= rclk_lvl_d;
            mr_n_q <= mr_n_d;
            pr_n_q <= pr_n_d;
            rt_lvl_q <= rt_lvl_d;
        end
    end
    // Both port timings reduce to a rising edge of the same settled pin
    logic wr_edge, rd_edge, in_reset;
    assign wr_edge = wclk_lvl_d & ~wclk_lvl_q;
    assign rd_edge = rclk_lvl_d & ~rclk_lvl_q;
    assign in_reset = ~mr_n_q | ~pr_n_q;

    // Mode latch and offset registers; straps are taken by a clocked process
    mode_cfg_t cfg_q, cfg_d;
    offsets_t offs_q, offs_d;
    logic [DEPTH_W:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic [DATA_W-1:0] out_q, out_d;
    logic valid_q, valid_d, offs_sel_q, offs_sel_d;
    logic [DATA_W-1:0] mem_q [DEPTH];
    logic do_write, do_read, rd_fifo, wr_fifo, rd_offs, reread;
    logic [DEPTH_W:0] count, free;
    logic serial_bit;

    assign serial_bit = fall_through_mode_i;
    assign count = DEPTH_W'(0) + (wptr_q - rptr_q);
    assign free = DEPTH_CNT - count;
    // Asynchronous ports tie enables active, so one gate serves both timings
    assign do_write = wr_edge & ~write_enable_n_i & ~in_reset;
    assign do_read = rd_edge & ~read_enable_n_i & ~in_reset;
    assign wr_fifo = do_write & offset_access_n_i & (count != DEPTH_CNT);
    assign rd_offs = do_read & ~offset_access_n_i & ~cfg_q.async_read;
    assign reread = rt_lvl_d & ~rt_lvl_q & rd_edge & ~in_reset;
    assign rd_fifo = do_read & offset_access_n_i & (count != '0) & ~reread;

    always_comb
    begin
        cfg_d = cfg_q;
        offs_d = offs_q;
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        out_d = out_q;
        valid_d = valid_q;
        offs_sel_d = offs_sel_q;
        if (~mr_n_q)
        begin
            cfg_d.narrow_read = read_width_select_i;
            cfg_d.sync_flags = flag_timing_select_i;
            cfg_d.normal_rt_latency = retransmit_latency_select_i;
            cfg_d.fall_through = fall_through_mode_i;
            cfg_d.async_read = ~async_read_select_n_i;
            cfg_d.async_write = ~async_write_select_n_i;
            offs_d.empty_offs = EMPTY_OFFS_RST;
            offs_d.full_offs = FULL_OFFS_RST;
            wptr_d = '0;
            rptr_d = '0;
            out_d = DATA_ZERO;
            valid_d = 1'b0;
            offs_sel_d = 1'b0;
        end
        else if (~pr_n_q)
        begin
            // Configuration and offsets left alone on purpose
            wptr_d = '0;
            rptr_d = '0;
            out_d = DATA_ZERO;
            valid_d = 1'b0;
            offs_sel_d = 1'b0;
        end
        else
        begin
            if (wr_edge & ~serial_offset_load_enable_n_i)
                offs_d = {offs_q[2*OFFS_W-2:0], serial_bit};
            else if (do_write & ~offset_access_n_i)
            begin
                // Parallel load alternates empty then full offset
                if (offs_sel_q)
                    offs_d.full_offs = write_data_i[OFFS_W-1:0];
                else
                    offs_d.empty_offs = write_data_i[OFFS_W-1:0];
                offs_sel_d = ~offs_sel_q;
            end
            if (wr_fifo)
                wptr_d = wptr_q + 1'b1;
            if (reread)
            begin
                rptr_d = '0;
                valid_d = cfg_q.fall_through & (wptr_q != '0);
            end
            else if (rd_offs)
            begin
                out_d = DATA_ZERO;
                out_d[OFFS_W-1:0] = offs_sel_q ? offs_q.full_offs : offs_q.empty_offs;
                offs_sel_d = ~offs_sel_q;
            end
            else if (rd_fifo)
            begin
                out_d = mem_q[rptr_q[DEPTH_W-1:0]];
                if (cfg_q.narrow_read)
                    out_d[DATA_W-1:HALF_W] = '0;
                rptr_d = rptr_q + 1'b1;
                valid_d = 1'b1;
            end
        end
    end
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_q <= '0;
            offs_q <= {EMPTY_OFFS_RST, FULL_OFFS_RST};
            wptr_q <= '0;
            rptr_q <= '0;
            out_q <= DATA_ZERO;
            valid_q <= 1'b0;
            offs_sel_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            offs_q <= offs_d;
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            out_q <= out_d;
            valid_q <= valid_d;
            offs_sel_q <= offs_sel_d;
        end
    end
    // Storage has no reset; stale words are never read past the pointers
    always_ff @(posedge sys_clk_i)
    begin
        if (wr_fifo)
            mem_q[wptr_q[DEPTH_W-1:0]] <= write_data_i;
    end

    // Flags; synchronous timing adds one register stage on the almost-flag paths, the empty flag is registered except in a reread cycle
    logic ae_raw, af_raw, ae_q, af_q, ae_d, af_d, ef_q, ef_d;
    assign ae_raw = (count >= (DEPTH_W+1)'(offs_q.empty_offs));
    assign af_raw = (free > (DEPTH_W+1)'(offs_q.full_offs));
    always_comb
    begin
        ae_d = ae_raw;
        af_d = af_raw;
        ef_d = cfg_q.fall_through ? valid_d : (count != '0);
    end
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ae_q <= 1'b0;
            af_q <= 1'b1;
            ef_q <= 1'b0;
        end
        else
        begin
            ae_q <= ae_d;
            af_q <= af_d;
            ef_q <= ef_d;
        end
    end
    assign almost_empty_flag_n_o = cfg_q.sync_flags ? ae_q : ae_raw;
    assign almost_full_flag_n_o = cfg_q.sync_flags ? af_q : af_raw;
    assign empty_flag_n_o = reread ? cfg_q.fall_through : ef_q;
    assign read_data_out_o = out_q;
    always_comb
    begin
        read_data_out_en_n_o = {DATA_W{output_enable_n_i}};
        if (cfg_q.narrow_read)
            read_data_out_en_n_o[DATA_W-1:HALF_W] = '1;
    end

    // Named steps of a read: the request cycle and the pointer step after it
    sequence seq_fifo_read;
        rd_fifo;
    endsequence
    sequence seq_ptr_step;
        (rptr_q == $past(rptr_q) + 1'b1) && valid_q;
    endsequence
    chk_write_gated: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        write_enable_n_i |=> $stable(wptr_q) || (wptr_q == '0))
        else $error("write pointer moved without enable");
    chk_read_gated: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (read_enable_n_i && !reread) |=> $stable(rptr_q) || (rptr_q == '0))
        else $error("read pointer moved without enable");
    chk_reread_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        reread |=> (rptr_q == '0)
        && (wptr_q == $past(wptr_q) + {{DEPTH_W{1'b0}}, $past(wr_fifo)}))
        else $error("reread did not zero read pointer");
    chk_partial_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (mr_n_q && !pr_n_q)
        |=> (wptr_q == '0) && (out_q == DATA_ZERO) && $stable(offs_q))
        else $error("partial reset state wrong");
    chk_ae_level: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !cfg_q.sync_flags
        |-> almost_empty_flag_n_o == (count >= (DEPTH_W+1)'(offs_q.empty_offs)))
        else $error("almost-empty flag wrong");
    chk_af_level: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !cfg_q.sync_flags
        |-> almost_full_flag_n_o == (free > (DEPTH_W+1)'(offs_q.full_offs)))
        else $error("almost-full flag wrong");
    chk_oe_float: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        output_enable_n_i |-> read_data_out_en_n_o == '1)
        else $error("outputs driven while disabled");
    chk_master_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !mr_n_q |=> cfg_q.narrow_read == $past(read_width_select_i))
        else $error("width not latched");
    chk_serial_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (mr_n_q && pr_n_q && serial_offset_load_enable_n_i && offset_access_n_i)
        |=> $stable(offs_q))
        else $error("offsets changed without load enable");
    chk_read_advance: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        seq_fifo_read |=> seq_ptr_step)
        else $error("read did not advance pointer");
    chk_offs_readback: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_offs && !offs_sel_q)
        |=> out_q == {{(DATA_W-OFFS_W){1'b0}}, $past(offs_q.empty_offs)})
        else $error("offset read-back wrong");
    chk_narrow_upper: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        cfg_q.narrow_read |-> out_q[DATA_W-1:HALF_W] == '0)
        else $error("upper outputs carry data in narrow mode");
    chk_sync_flags: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (cfg_q.sync_flags && mr_n_q)
        |=> (almost_empty_flag_n_o == $past(ae_raw)) && (almost_full_flag_n_o == $past(af_raw)))
        else $error("synchronous flags not registered");
    chk_wide_enable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!cfg_q.narrow_read && !output_enable_n_i) |-> read_data_out_en_n_o == '0)
        else $error("outputs not driven while enabled");
endmodule
`default_nettype wire

// ---- testbench/fifo_pin_model.sv ----
// Producer and consumer pin model facing the FIFO controller
`timescale 1ns/1ps
`default_nettype none
module fifo_pin_model
    import fifo_ctl_pkg::*;
(
    input wire logic sys_clk_i,
    output logic write_clk_o,
    output logic write_enable_n_o,
    output logic [DATA_W-1:0] write_data_o,
    output logic read_clk_o,
    output logic read_enable_n_o,
    output logic reread_request_o
);
    initial
    begin
        write_clk_o = 1'b0;
        write_enable_n_o = 1'b1;
        write_data_o = DATA_ZERO;
        read_clk_o = 1'b0;
        read_enable_n_o = 1'b1;
        reread_request_o = 1'b0;
    end
    // Each pin level lasts five system cycles, three above the two-cycle sampler minimum
    task automatic push(input logic [DATA_W-1:0] d, input logic en);
        @(posedge sys_clk_i);
        write_data_o <= d;
        write_enable_n_o <= ~en;
        repeat (5) @(posedge sys_clk_i);
        write_clk_o <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        write_clk_o <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        write_enable_n_o <= 1'b1;
        // Released data shows the inverse so stale values never match
        write_data_o <= ~d;
    endtask
    task automatic pull(input logic en, input logic rr);
        @(posedge sys_clk_i);
        read_enable_n_o <= ~en;
        repeat (5) @(posedge sys_clk_i);
        read_clk_o <= 1'b1;
        reread_request_o <= rr;
        repeat (5) @(posedge sys_clk_i);
        read_clk_o <= 1'b0;
        reread_request_o <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        read_enable_n_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- testbench/dual_clock_fifo_port_control_test.sv ----
// Self-checking bench for the FIFO controller
`timescale 1ns/1ps
`default_nettype none
module dual_clock_fifo_port_control_test;
    import fifo_ctl_pkg::*;
    logic sys_clk, rst, mrs_n, prs_n, width_sel, oe_n, ft_sel, offs_n;
    logic wclk, wen_n, rclk, ren_n, rr;
    logic [DATA_W-1:0] wdata, q, q_en_n;
    logic ef_n, ae_n, af_n;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    fifo_pin_model PM (.sys_clk_i(sys_clk), .write_clk_o(wclk), .write_enable_n_o(wen_n),
        .write_data_o(wdata), .read_clk_o(rclk), .read_enable_n_o(ren_n),
        .reread_request_o(rr));
    fifo_ctl DUT (.sys_clk_i(sys_clk), .rst_i(rst), .master_reset_n_i(mrs_n),
        .partial_reset_n_i(prs_n), .read_width_select_i(width_sel),
        .flag_timing_select_i(ft_sel), .retransmit_latency_select_i(1'b0),
        .async_read_select_n_i(1'b1), .async_write_select_n_i(1'b1),
        .fall_through_mode_i(1'b0), .write_clk_i(wclk), .write_enable_n_i(wen_n),
        .write_data_i(wdata), .read_clk_i(rclk), .read_enable_n_i(ren_n),
        .output_enable_n_i(oe_n), .offset_access_n_i(offs_n),
        .serial_offset_load_enable_n_i(1'b1), .reread_request_i(rr),
        .read_data_out_o(q), .read_data_out_en_n_o(q_en_n), .empty_flag_n_o(ef_n),
        .almost_empty_flag_n_o(ae_n), .almost_full_flag_n_o(af_n));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic wrap_up();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Ceiling sits well above the roughly 1240 cycles the tests need
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic do_mreset(input logic narrow);
        @(posedge sys_clk);
        mrs_n <= 1'b0;
        width_sel <= narrow;
        ft_sel <= narrow;
        repeat (8) @(posedge sys_clk);
        mrs_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
    endtask
    task automatic t_idle();
        chk({15'h0000, ef_n, ae_n, af_n}, 18'h00001);
        chk(q, DATA_ZERO);
        PM.push(18'h2aaaa, 1'b0);
        chk({17'h00000, ef_n}, 18'h00000);
        $display("Test idle done");
    endtask
    task automatic t_fill();
        for (int i = 0; i < 57; i++)
        begin
            PM.push(18'h00100 + 18'(i), 1'b1);
            if (i == 5 || i == 6)
                chk({17'h00000, ae_n}, {17'h00000, i == 6});
            if (i == 55 || i == 56)
                chk({17'h00000, af_n}, {17'h00000, i == 55});
        end
        chk({17'h00000, ef_n}, 18'h00001);
        $display("Test fill done");
    endtask
    task automatic t_drain();
        for (int i = 0; i < 3; i++)
        begin
            PM.pull(1'b1, 1'b0);
            chk(q, 18'h00100 + 18'(i));
        end
        chk(q_en_n, DATA_ZERO);
        PM.pull(1'b0, 1'b0);
        chk(q, 18'h00102);
        @(posedge sys_clk);
        oe_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(q_en_n, 18'h3ffff);
        oe_n <= 1'b0;
        PM.pull(1'b0, 1'b1);
        PM.pull(1'b1, 1'b0);
        chk(q, 18'h00100);
        $display("Test drain done");
    endtask
    // The empty offset is moved off its default first, so the partial reset check means something
    task automatic t_partial();
        @(posedge sys_clk);
        offs_n <= 1'b0;
        PM.push(18'h00003, 1'b1);
        PM.push(18'h00007, 1'b1);
        PM.pull(1'b1, 1'b0);
        chk(q, 18'h00003);
        offs_n <= 1'b1;
        @(posedge sys_clk);
        prs_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        prs_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chk({q[DATA_W-1:1], ef_n}, DATA_ZERO);
        for (int i = 0; i < 3; i++)
        begin
            PM.push(18'h00200 + 18'(i), 1'b1);
            if (i == 1)
                chk({17'h00000, ae_n}, 18'h00000);
        end
        chk({17'h00000, ae_n}, 18'h00001);
        $display("Test partial done");
    endtask
    task automatic t_narrow();
        do_mreset(1'b1);
        offs_n <= 1'b0;
        PM.pull(1'b1, 1'b0);
        chk(q, {11'h000, EMPTY_OFFS_RST});
        offs_n <= 1'b1;
        PM.push(18'h3ffff, 1'b1);
        chk({16'h0000, ae_n, af_n}, 18'h00001);
        PM.pull(1'b1, 1'b0);
        chk(q_en_n, 18'h3fe00);
        chk(q & 18'h3fe00, DATA_ZERO);
        chk(q, 18'h001ff);
        $display("Test narrow done");
    endtask
    initial
    begin
        rst = 1'b1;
        mrs_n = 1'b1;
        prs_n = 1'b1;
        width_sel = 1'b0;
        ft_sel = 1'b0;
        offs_n = 1'b1;
        oe_n = 1'b0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        do_mreset(1'b0);
        t_idle();
        t_fill();
        t_drain();
        t_partial();
        t_narrow();
        wrap_up();
    end
endmodule
`default_nettype wire
